// *** rtc_regs.vh ***
// constants for the serial timekeeping register set: offsets, field positions,
// reset values and timing counts; assumes a 20 MHz core clock
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// clock period and time bases
`define RTC_CLK_PERIOD_NS 50
`define RTC_TICK_NS 10000000
`define RTC_BATT_HOURS 24

// serial frame sizes
`define RTC_PATTERN_BITS 64
`define RTC_XFER_BITS 64

// comparison pattern, sent first bit first (plain default value)
`define RTC_MATCH_PATTERN 64'hC5A3_3A5C_C5A3_3A5C

// register indexes inside the 64-bit frame
`define RTC_REG_SUBSEC 0
`define RTC_REG_SECONDS 1
`define RTC_REG_MINUTES 2
`define RTC_REG_HOURS 3
`define RTC_REG_WEEKDAY 4
`define RTC_REG_DATE 5
`define RTC_REG_MONTH 6
`define RTC_REG_YEAR 7

// field positions
`define RTC_HOUR_MODE_BIT 7
`define RTC_HOUR_PM_BIT 5
`define RTC_OSC_HALT_BIT 5

// bits kept on load; zero bits read back as zero (register 7 in top byte)
`define RTC_KEEP_MASK 64'hFF1F3F37BF7F7FFF

// reset values of the eight registers (register 7 in top byte)
`define RTC_RESET_VALUE 64'h0001011100000000
`endif

// *** pin_sync.v ***
// three-stage synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clock; a change is taken when stages two and three agree
`default_nettype none
module pin_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clock, // core clock
    input wire rst, // asynchronous reset, active high
    input wire [W-1:0] pin, // raw pin levels
    output reg [W-1:0] level // filtered synchronised levels
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    genvar i;

    // per-bit chain; stage1 feeds stage2 only
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    stage1[i] <= INIT[i];
                    stage2[i] <= INIT[i];
                    stage3[i] <= INIT[i];
                    level[i] <= INIT[i];
                end
                else
                begin
                    stage1[i] <= pin[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i])
                        level[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** bcd_calendar.v ***
// eight bcd time registers with hundredth-second advance and parallel load
// assumes tick is a one-cycle pulse every hundredth second and load data is already masked
`default_nettype none
`include "rtc_regs.vh"
module bcd_calendar (
    input wire clock, // core clock
    input wire rst, // asynchronous reset, active high
    input wire tick, // hundredth-second pulse
    input wire load, // load all eight registers
    input wire [63:0] load_data, // new register values, register 0 lowest
    output wire [63:0] regs // current register values, register 0 lowest
);
    reg [7:0] r0;
    reg [7:0] r1;
    reg [7:0] r2;
    reg [7:0] r3;
    reg [7:0] r4;
    reg [7:0] r5;
    reg [7:0] r6;
    reg [7:0] r7;
    reg [7:0] next_hour;
    reg [7:0] hour_step;
    reg day_carry;
    wire [63:0] init = `RTC_RESET_VALUE;
    wire run;
    wire c1;
    wire c2;
    wire c3;
    wire c5;
    wire c6;
    wire c7;

    // bcd increment of a two-digit value
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9)
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            else
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last date of a month in bcd, leap years by year mod 4
    function [7:0] month_last;
        input [7:0] m;
        input [7:0] y;
        begin
            case (m)
                8'h02: month_last = ((!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
                                     (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6))) ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
                default: month_last = 8'h31;
            endcase
        end
    endfunction

    assign regs = {r7, r6, r5, r4, r3, r2, r1, r0};

    // carry chain; oscillator bit zero lets the counters run
    assign run = tick && !r4[`RTC_OSC_HALT_BIT];
    assign c1 = run && (r0 == 8'h99);
    assign c2 = c1 && (r1 == 8'h59);
    assign c3 = c2 && (r2 == 8'h59);
    assign c5 = day_carry && (r5 == month_last(r6, r7));
    assign c6 = c5 && (r6 == 8'h12);
    assign c7 = c6 && (r7 == 8'h99);

    // hour step in 12-hour or 24-hour format
    always @*
    begin
        next_hour = r3;
        day_carry = 1'b0;
        hour_step = bcd_inc({3'h0, r3[4:0]});
        if (r3[`RTC_HOUR_MODE_BIT])
        begin
            // 12-hour: bit 5 marks afternoon
            if (r3[4:0] == 5'h12)
                next_hour = {r3[7:5], 5'h01};
            else if (r3[4:0] == 5'h11)
            begin
                next_hour = {r3[7], 1'b0, ~r3[5], 5'h12};
                day_carry = c3 && r3[5];
            end
            else
                next_hour = {r3[7:5], hour_step[4:0]} & 8'hBF;
        end
        else
        begin
            // 24-hour: bit 5 is the upper tens bit
            if (r3[5:0] == 6'h23)
            begin
                next_hour = 8'h00;
                day_carry = c3;
            end
            else
                next_hour = bcd_inc({2'h0, r3[5:0]});
        end
    end

    // register update; bcd rollover at each limit
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r0 <= 8'h00;
            r1 <= 8'h00;
            r2 <= 8'h00;
            r3 <= 8'h00;
            r4 <= 8'h11;
            r5 <= 8'h01;
            r6 <= 8'h01;
            r7 <= 8'h00;
        end
        else if (load)
        begin
            r0 <= load_data[7:0];
            r1 <= load_data[15:8];
            r2 <= load_data[23:16];
            r3 <= load_data[31:24];
            r4 <= load_data[39:32];
            r5 <= load_data[47:40];
            r6 <= load_data[55:48];
            r7 <= load_data[63:56];
        end
        else
        begin
            if (run)
                r0 <= c1 ? 8'h00 : bcd_inc(r0);
            if (c1)
                r1 <= c2 ? 8'h00 : bcd_inc(r1);
            if (c2)
                r2 <= c3 ? 8'h00 : bcd_inc(r2);
            if (c3)
                r3 <= next_hour;
            if (day_carry)
                r4 <= {r4[7:3], (r4[2:0] == 3'h7) ? 3'h1 : r4[2:0] + 3'h1};
            if (day_carry)
                r5 <= c5 ? 8'h01 : bcd_inc(r5);
            if (c5)
                r6 <= c6 ? 8'h01 : bcd_inc(r6);
            if (c6)
                r7 <= c7 ? 8'h00 : bcd_inc(r7);
        end
    end

    // reset constant kept for reference only; the reset branch loads literal values
    wire unused_init = ^init;
endmodule
`default_nettype wire

// *** serial_rtc_register_access.v ***
// serial timekeeping access on the sram strobes, pattern unlock and battery monitor
// assumes strobes and the data line are asynchronous pins; battery compare and supply
// good come from analogue cells as levels
//
// How it works
// - 64 matching writes unlock; mismatch freezes pointer
// - any read restarts recognition at first bit
// - next 64 cycles move time bits serially
// - memory stays selected until recognition completes
// - eight bytes shift one bit per cycle
// - all register contents are bcd coded
// - transfer walks bit 0 reg 0 upward
// - hours bit 7 selects 12-hour mode
// - hours bit 5 is pm or tens
// - day bit 5 zero runs oscillator
// - unused bits read zero, writes ignored
// - eight registers hold hundredths through year
// - date tens bits 5:4, units 3:0
// - battery check at power-up and daily
// - weak flag holds until a passing check
// - checks only while main supply nominal
`default_nettype none
`include "rtc_regs.vh"
module serial_rtc_register_access #(
    parameter [31:0] TICK_CYCLES = `RTC_TICK_NS / `RTC_CLK_PERIOD_NS,
    parameter [63:0] BATT_CYCLES = `RTC_BATT_HOURS * 64'd3600 * 64'd1000000000 / `RTC_CLK_PERIOD_NS,
    parameter [63:0] MATCH_PATTERN = `RTC_MATCH_PATTERN
) (
    input wire clock, // core clock, 20 MHz
    input wire rst, // power-up reset, asynchronous, active high
    input wire chip_enable_n, // chip enable pin, active low
    input wire output_enable_n, // output enable pin, active low
    input wire write_enable_n, // write enable pin, active low
    input wire serial_data_line_in, // data line 0 level from the pin
    output reg serial_data_line_out, // data line 0 drive value
    output wire serial_data_line_oe, // data line 0 driven while high
    output wire memory_select, // high while accesses go to the sram array
    input wire battery_ok, // battery comparator, high when above threshold
    input wire supply_nominal, // main supply in tolerance
    output wire battery_weak_flag_out, // open-drain value, always low
    output wire battery_weak_flag_oe, // pulls the pin low while the battery is weak
    output wire clock_unlocked // high during the 64-cycle transfer
);
    wire ce_n_s;
    wire oe_n_s;
    wire we_n_s;
    wire data_s;
    wire batt_ok_s;
    wire supply_s;
    wire rd_act;
    wire wr_act;
    wire [63:0] cal_regs;
    reg rd_prev;
    reg wr_prev;
    reg wr_bit;
    reg unlocked;
    reg frozen;
    reg [5:0] pointer;
    reg [5:0] count;
    reg wrote;
    reg [63:0] snapshot;
    reg [63:0] rx;
    reg cal_load;
    reg [31:0] tick_count;
    reg tick;
    reg [63:0] batt_count;
    reg batt_due;
    reg battery_weak_flag;

    // pin synchronisers: strobes idle high, data and analogue levels
    pin_sync #(.W(3), .INIT(3'h7)) strobe_sync (
        .clock(clock),
        .rst(rst),
        .pin({chip_enable_n, output_enable_n, write_enable_n}),
        .level({ce_n_s, oe_n_s, we_n_s})
    );
    pin_sync #(.W(3), .INIT(3'h0)) level_sync (
        .clock(clock),
        .rst(rst),
        .pin({serial_data_line_in, battery_ok, supply_nominal}),
        .level({data_s, batt_ok_s, supply_s})
    );

    // bus cycle decode: write wins when both enables are low
    assign rd_act = !ce_n_s && !oe_n_s && we_n_s;
    assign wr_act = !ce_n_s && !we_n_s;

    // memory is disabled only during the clock transfer
    assign memory_select = !unlocked;
    assign clock_unlocked = unlocked;
    assign serial_data_line_oe = unlocked && rd_act;
    assign battery_weak_flag_out = 1'b0;
    assign battery_weak_flag_oe = battery_weak_flag;

    // strobe history and data latched while the write strobe is low
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
            wr_bit <= 1'b0;
        end
        else
        begin
            rd_prev <= rd_act;
            wr_prev <= wr_act;
            if (wr_act)
                wr_bit <= data_s;
        end
    end

    // recognition pointer and serial transfer sequencer
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            unlocked <= 1'b0;
            frozen <= 1'b0;
            pointer <= 6'h00;
            count <= 6'h00;
            wrote <= 1'b0;
            snapshot <= 64'h0000000000000000;
            rx <= 64'h0000000000000000;
            cal_load <= 1'b0;
        end
        else
        begin
            cal_load <= 1'b0;
            if (!unlocked)
            begin
                if (rd_act && !rd_prev)
                begin
                    // a read aborts and restarts recognition
                    pointer <= 6'h00;
                    frozen <= 1'b0;
                end
                else if (wr_prev && !wr_act && !frozen)
                begin
                    if (wr_bit == MATCH_PATTERN[pointer])
                    begin
                        pointer <= pointer + 6'h01;
                        if (pointer == 6'h3F)
                        begin
                            // pattern complete: capture a stable copy
                            unlocked <= 1'b1;
                            count <= 6'h00;
                            wrote <= 1'b0;
                            snapshot <= cal_regs;
                            rx <= cal_regs;
                        end
                    end
                    else
                        frozen <= 1'b1;
                end
            end
            else if ((rd_prev && !rd_act) || (wr_prev && !wr_act))
            begin
                // one bit per cycle, bit 0 of register 0 first
                if (wr_prev)
                begin
                    rx[count] <= wr_bit;
                    wrote <= 1'b1;
                end
                count <= count + 6'h01;
                if (count == 6'h3F)
                begin
                    // full frame done: load only if the host wrote
                    unlocked <= 1'b0;
                    pointer <= 6'h00;
                    frozen <= 1'b0;
                    cal_load <= wrote || wr_prev;
                end
            end
        end
    end

    // transmit bit from the snapshot, registered
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            serial_data_line_out <= 1'b0;
        else
            serial_data_line_out <= snapshot[count];
    end

    // time registers; zero bits dropped on load
    bcd_calendar calendar (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .load(cal_load),
        .load_data(rx & `RTC_KEEP_MASK),
        .regs(cal_regs)
    );

    // hundredth-second tick
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tick_count <= 32'h00000000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_count == TICK_CYCLES - 32'h00000001);
            if (tick_count == TICK_CYCLES - 32'h00000001)
                tick_count <= 32'h00000000;
            else
                tick_count <= tick_count + 32'h00000001;
        end
    end

    // battery monitor: check pending from reset, then every interval
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            batt_count <= 64'h0000000000000000;
            batt_due <= 1'b1;
            battery_weak_flag <= 1'b0;
        end
        else
        begin
            if (batt_count == BATT_CYCLES - 64'h0000000000000001)
                batt_count <= 64'h0000000000000000;
            else
                batt_count <= batt_count + 64'h0000000000000001;
            if (batt_due && supply_s)
            begin
                batt_due <= 1'b0;
                battery_weak_flag <= !batt_ok_s;
            end
            else if (batt_count == BATT_CYCLES - 64'h0000000000000001)
                batt_due <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** rtc_access_props.sv ***
// checker for the serial timekeeping access block, port relations only
// assumes one core clock and an asynchronous active high reset
`default_nettype none
module rtc_access_props (
    input wire logic clock, // core clock
    input wire logic rst, // reset, active high
    input wire logic chip_enable_n, // chip enable pin
    input wire logic output_enable_n, // output enable pin
    input wire logic write_enable_n, // write enable pin
    input wire logic serial_data_line_in, // data line level
    input wire logic serial_data_line_out, // drive value
    input wire logic serial_data_line_oe, // drive enable
    input wire logic memory_select, // sram selected
    input wire logic battery_ok, // battery comparator
    input wire logic supply_nominal, // supply good
    input wire logic battery_weak_flag_out, // open-drain value
    input wire logic battery_weak_flag_oe, // weak pull enable
    input wire logic clock_unlocked // transfer active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] good_run;
    logic [3:0] bad_run;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // saturating runs of good and bad battery levels
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            good_run <= 4'h0;
            bad_run <= 4'h0;
        end
        else
        begin
            good_run <= !battery_ok ? 4'h0 : (good_run == 4'hF) ? good_run : good_run + 4'h1;
            bad_run <= battery_ok ? 4'h0 : (bad_run == 4'hF) ? bad_run : bad_run + 4'h1;
        end
    end
    AST_RELEASE_IDLE: assert property ($fell(rst) |-> memory_select && !clock_unlocked)
        else $error("bus not idle after reset");
    AST_MEM_OFF_ONLY_UNLOCKED: assert property (memory_select == !clock_unlocked)
        else $error("memory select and unlock disagree");
    AST_DRIVE_ONLY_UNLOCKED: assert property (serial_data_line_oe |-> clock_unlocked)
        else $error("data line driven while locked");
    AST_DRIVE_NEEDS_READ: assert property ($rose(serial_data_line_oe) |-> !output_enable_n && !chip_enable_n)
        else $error("data line driven without read strobe");
    AST_DRIVE_ENDS: assert property ($rose(output_enable_n) |-> ##[1:6] !serial_data_line_oe)
        else $error("data line still driven after read");
    AST_BIT_STEADY: assert property (serial_data_line_oe && $past(serial_data_line_oe) |-> $stable(serial_data_line_out))
        else $error("data bit changed during read");
    AST_UNLOCK_ON_WRITE: assert property ($rose(clock_unlocked) |-> output_enable_n)
        else $error("unlock not on a write");
    AST_FLAG_RISE_CAUSE: assert property ($rose(battery_weak_flag_oe) |-> good_run < 4'hA)
        else $error("weak flag raised with good battery");
    AST_FLAG_FALL_CAUSE: assert property ($fell(battery_weak_flag_oe) |-> bad_run < 4'hA)
        else $error("weak flag cleared with weak battery");
    AST_NO_CHECK_ON_BACKUP: assert property ((!supply_nominal) [*6] |-> $stable(battery_weak_flag_oe))
        else $error("battery check without supply");
    AST_OPEN_DRAIN: assert property (!battery_weak_flag_out)
        else $error("weak flag drives high");
    COV_UNLOCK: cover property ($rose(clock_unlocked));
    COV_RELOCK: cover property ($fell(clock_unlocked));
    COV_READ_BIT: cover property ($rose(serial_data_line_oe));
    COV_WEAK: cover property ($rose(battery_weak_flag_oe));
endmodule
bind serial_rtc_register_access rtc_access_props rtc_access_props_i (.clock, .rst, .chip_enable_n,
    .output_enable_n, .write_enable_n, .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe,
    .memory_select, .battery_ok, .supply_nominal, .battery_weak_flag_out, .battery_weak_flag_oe,
    .clock_unlocked);
`default_nettype wire

// *** sram_host.sv ***
// host model on the sram strobes, one bus cycle per task call
// assumes the device drives data line 0 only while its enable is high
`default_nettype none
module sram_host (
    input wire logic clock, // core clock
    output logic chip_enable_n, // chip enable
    output logic output_enable_n, // output enable
    output logic write_enable_n, // write enable
    output wire logic line, // resolved data line level
    input wire logic dev_out, // device drive value
    input wire logic dev_oe // device drive enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drive = 1'b0;
    logic drive_val = 1'b0;
    logic last = 1'b0;
    // released line shows the inverse of its last level
    assign line = dev_oe ? dev_out : drive ? drive_val : ~last;
    always @(posedge clock)
        last <= line;
    initial
    begin
        chip_enable_n = 1'b1;
        output_enable_n = 1'b1;
        write_enable_n = 1'b1;
    end
    // strobes low six clocks, high six clocks; a read restarts recognition
    task automatic cycle(input bit wr, input bit val, output logic got);
        @(posedge clock);
        #2;
        chip_enable_n = 1'b0;
        write_enable_n = !wr;
        output_enable_n = wr;
        drive = wr;
        drive_val = val;
        repeat (6) @(posedge clock);
        got = line;
        #2;
        chip_enable_n = 1'b1;
        write_enable_n = 1'b1;
        output_enable_n = 1'b1;
        repeat (6) @(posedge clock);
        #2;
        drive = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// bench for the serial timekeeping block: unlock, transfers, rollover, battery
// assumes a 50 ns core clock and shortened tick and battery counts
`default_nettype none
`include "rtc_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] KEEP = 64'hFF1F3F37BF7F7FFF; // bits that hold value
    localparam logic [63:0] PAT = `RTC_MATCH_PATTERN;
    logic clock, rst, battery_ok, supply_nominal, b;
    logic [63:0] w, r;
    wire ce_n, oe_n, we_n, line, dq_out, dq_oe, mem_sel, weak_out, weak_oe, unlocked;
    int bad_count, compares, cycles, seed;
    serial_rtc_register_access #(.TICK_CYCLES(32'd2000), .BATT_CYCLES(64'd50)) serial_rtc_register_access_i (
        .clock(clock), .rst(rst), .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .serial_data_line_in(line), .serial_data_line_out(dq_out), .serial_data_line_oe(dq_oe),
        .memory_select(mem_sel), .battery_ok(battery_ok), .supply_nominal(supply_nominal),
        .battery_weak_flag_out(weak_out), .battery_weak_flag_oe(weak_oe), .clock_unlocked(unlocked));
    sram_host sram_host_i (.clock(clock), .chip_enable_n(ce_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .line(line), .dev_out(dq_out), .dev_oe(dq_oe));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // restart with a read, then n pattern writes first bit first, one bit flipped at bad
    task automatic pat(input int n, input int bad);
        logic g;
        sram_host_i.cycle(1'b0, 1'b0, g);
        for (int i = 0; i < n; i++)
        begin
            if (i == 63)
                check("select before last", 64'h1, {63'h0, mem_sel});
            sram_host_i.cycle(1'b1, PAT[i] ^ (i == bad), g);
        end
    endtask
    // unlock, then a whole 64-bit transfer in one direction
    task automatic xfer(input logic [63:0] wv, input bit wr, output logic [63:0] rv);
        logic g;
        pat(64, -1);
        check("unlocked", 64'h1, {63'h0, unlocked});
        for (int i = 0; i < 64; i++)
        begin
            sram_host_i.cycle(wr, wv[i], g);
            rv[i] = g;
        end
        repeat (2) @(posedge clock);
        check("relocked", 64'h0, {63'h0, unlocked});
    endtask
    // write a frame, read it back, expect the kept bits
    task automatic round(input logic [63:0] wv);
        xfer(wv, 1'b1, r);
        xfer(64'h0, 1'b0, r);
        check("readback", wv & KEEP, r);
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    initial
    begin
        rst = 1'b1;
        battery_ok = 1'b0;
        supply_nominal = 1'b1;
        bad_count = 0;
        compares = 0;
        cycles = 0;
        seed = $urandom(72202);
        repeat (5) @(posedge clock);
        #2;
        rst = 1'b0;
        repeat (12) @(posedge clock);
        check("weak at power-up", 64'h1, {63'h0, weak_oe});
        battery_ok = 1'b1;
        repeat (3) @(posedge clock);
        check("weak held", 64'h1, {63'h0, weak_oe});
        repeat (70) @(posedge clock);
        check("weak cleared", 64'h0, {63'h0, weak_oe});
        supply_nominal = 1'b0;
        battery_ok = 1'b0;
        repeat (150) @(posedge clock);
        check("no check on backup", 64'h0, {63'h0, weak_oe});
        supply_nominal = 1'b1;
        repeat (70) @(posedge clock);
        check("weak on interval", 64'h1, {63'h0, weak_oe});
        battery_ok = 1'b1;
        repeat (70) @(posedge clock);
        // mismatch freezes recognition; an aborted start is retried
        pat(64, 10);
        check("locked after mismatch", 64'h0, {63'h0, unlocked});
        check("memory kept", 64'h1, {63'h0, mem_sel});
        pat(20, -1);
        round(64'hFFFFFFF7FFFFFFFF);
        // random frames with the oscillator halted and fixed day bits
        for (int k = 0; k < 3; k++)
        begin
            w = {$urandom, $urandom};
            w[37:35] = 3'h6;
            round(w);
        end
        // 12-hour pm 11:59:59.99 Sat 31 Dec 99 running; align so one tick falls between load and snapshot
        while (cycles % 2000 != 0)
            @(posedge clock);
        w = 64'h99123117B1595999;
        xfer(w, 1'b1, r);
        xfer(64'h0, 1'b0, r);
        check("rollover", 64'h0001011192000000, r);
        wrap_up;
    end
endmodule
`default_nettype wire
